// ---- cmp_pkg.sv ----
// package: comparator control constants, offsets, fields
package cmp_pkg;
    // ****************************************************
    // register byte offsets
    // ****************************************************
    localparam logic [7:0] OFS_CTRL_STATUS  = 8'h00;
    localparam logic [7:0] OFS_SPECIAL_IO   = 8'h04;
    localparam logic [7:0] OFS_IRQ_STATUS   = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK     = 8'h0c;
    localparam logic [7:0] OFS_MUX_CTRL     = 8'h10;
    // ****************************************************
    // comparator control status fields
    // ****************************************************
    localparam int BIT_POWER_OFF     = 7;
    localparam int BIT_BANDGAP_SEL   = 6;
    localparam int BIT_OUTPUT_FLAG   = 5;
    localparam int BIT_EVENT_FLAG    = 4;
    localparam int BIT_IRQ_ENABLE    = 3;
    localparam int BIT_CAPTURE_ROUTE = 2;
    localparam int BIT_MODE_HIGH     = 1;
    localparam int BIT_MODE_LOW      = 0;
    // ****************************************************
    // special function io and mux control fields
    // ****************************************************
    localparam int BIT_NEG_MUX_EN    = 3;
    localparam int BIT_CONV_ENABLE   = 3;
    localparam int CHAN_LSB          = 0;
    localparam int CHAN_WIDTH        = 3;
    // ****************************************************
    // interrupt status bits
    // ****************************************************
    localparam int IRQ_BIT_EVENT     = 0;
    localparam int IRQ_BIT_RISE      = 1;
    localparam int IRQ_BIT_FALL      = 2;
    localparam int IRQ_WIDTH         = 3;
    // ****************************************************
    // reset values
    // ****************************************************
    localparam logic [7:0] RST_CTRL  = 8'h00;
    localparam logic [7:0] RST_SPIO  = 8'h00;
    localparam logic [2:0] RST_MASK  = 3'h0;
    localparam logic [3:0] RST_MUX   = 4'h0;
    // ****************************************************
    // event modes
    // ****************************************************
    typedef enum logic [1:0] {
        MODE_TOGGLE   = 2'b00,
        MODE_RESERVED = 2'b01,
        MODE_FALLING  = 2'b10,
        MODE_RISING   = 2'b11
    } event_mode_e;
endpackage

// ---- cmp_edge_if.sv ----
// interface: synchronized comparator sample and edge pulses
`timescale 1ns/1ps
interface cmp_edge_if;
    logic level;
    logic rise;
    logic fall;
    modport src (output level, output rise, output fall);
    modport dst (input  level, input  rise, input  fall);
endinterface

// ---- cmp_sync.sv ----
// module: two-stage synchronizer and edge detector for comparator result
`timescale 1ns/1ps
module cmp_sync (
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic raw_i,
    cmp_edge_if.src   edge_if
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    // two flops before any use
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= raw_i;
            sync_ff <= meta_ff;
        end
    end

    // previous sample
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= sync_ff;
        end
    end

    assign edge_if.level = sync_ff;
    assign edge_if.rise  = sync_ff & ~prev_ff;
    assign edge_if.fall  = ~sync_ff & prev_ff;
endmodule // cmp_sync

// ---- comparator_control_logic.sv ----
// module: comparator control, event flag, apb registers, capture route
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module comparator_control_logic (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        cmp_raw_i,
    input  wire logic        global_irq_enable_i,
    input  wire logic        vector_ack_i,
    output logic             cmp_power_off_o,
    output logic             bandgap_select_o,
    output logic             neg_from_mux_o,
    output logic [2:0]       channel_select_o,
    output logic             capture_input_o,
    output logic             cmp_irq_req_o,
    output logic             irq_o
);
    // ****************************************************
    // declarations
    // ****************************************************
    cmp_edge_if sync_if ();

    logic       power_off_ff;
    logic       bandgap_ff;
    logic       event_flag_ff;
    logic       irq_en_ff;
    logic       capture_en_ff;
    logic [1:0] mode_ff;
    logic       neg_mux_en_ff;
    logic       conv_en_ff;
    logic [2:0] chan_ff;
    logic [2:0] irq_status_ff;
    logic [2:0] irq_mask_ff;
    logic       nxt_event;
    logic       wr_en;
    logic       rd_en;
    logic [7:0] ctrl_rd;
    logic [2:0] irq_set;
    logic       wr_ctrl;
    logic       wr_spio;
    logic       wr_stat;
    logic       wr_mask;
    logic       wr_mux;

    // ****************************************************
    // decode helpers
    // ****************************************************
    function automatic logic mode_match(input logic [1:0] m, input logic r, input logic f);
        unique case (cmp_pkg::event_mode_e'(m))
            cmp_pkg::MODE_TOGGLE:   mode_match = r | f;
            cmp_pkg::MODE_RESERVED: mode_match = 1'b0;
            cmp_pkg::MODE_FALLING:  mode_match = f;
            cmp_pkg::MODE_RISING:   mode_match = r;
        endcase
    endfunction

    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
        addr_is = (a == ofs);
    endfunction

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = addr_is(a, cmp_pkg::OFS_CTRL_STATUS) | addr_is(a, cmp_pkg::OFS_SPECIAL_IO) |
                  addr_is(a, cmp_pkg::OFS_IRQ_STATUS)  | addr_is(a, cmp_pkg::OFS_IRQ_MASK)   |
                  addr_is(a, cmp_pkg::OFS_MUX_CTRL);
    endfunction

    // ****************************************************
    // synchronizer and edge detect
    // ****************************************************
    cmp_sync u_sync (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .raw_i   (cmp_raw_i),
        .edge_if (sync_if.src)
    );

    // ****************************************************
    // apb access strobes
    // ****************************************************
    assign wr_en = psel_i & penable_i & pwrite_i & pready_o;
    assign rd_en = psel_i & ~penable_i & ~pwrite_i;

    // write strobes, access edge only
    assign wr_ctrl = wr_en & addr_is(paddr_i, cmp_pkg::OFS_CTRL_STATUS);
    assign wr_spio = wr_en & addr_is(paddr_i, cmp_pkg::OFS_SPECIAL_IO);
    assign wr_stat = wr_en & addr_is(paddr_i, cmp_pkg::OFS_IRQ_STATUS);
    assign wr_mask = wr_en & addr_is(paddr_i, cmp_pkg::OFS_IRQ_MASK);
    assign wr_mux  = wr_en & addr_is(paddr_i, cmp_pkg::OFS_MUX_CTRL);

    // no wait state: ready in first access cycle
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pready_o <= 1'b0;
        end else begin
            pready_o <= psel_i & ~penable_i;
        end
    end

    // error only with ready, on unmapped address
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pslverr_o <= 1'b0;
        end else begin
            pslverr_o <= psel_i & ~penable_i & ~addr_ok(paddr_i);
        end
    end

    // ****************************************************
    // control bits
    // ****************************************************
    // comparator power switch
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            power_off_ff <= cmp_pkg::RST_CTRL[cmp_pkg::BIT_POWER_OFF];
        end else if (wr_ctrl) begin
            power_off_ff <= pwdata_i[cmp_pkg::BIT_POWER_OFF];
        end
    end

    // positive input source
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            bandgap_ff <= cmp_pkg::RST_CTRL[cmp_pkg::BIT_BANDGAP_SEL];
        end else if (wr_ctrl) begin
            bandgap_ff <= pwdata_i[cmp_pkg::BIT_BANDGAP_SEL];
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            irq_en_ff <= cmp_pkg::RST_CTRL[cmp_pkg::BIT_IRQ_ENABLE];
        end else if (wr_ctrl) begin
            irq_en_ff <= pwdata_i[cmp_pkg::BIT_IRQ_ENABLE];
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            capture_en_ff <= cmp_pkg::RST_CTRL[cmp_pkg::BIT_CAPTURE_ROUTE];
        end else if (wr_ctrl) begin
            capture_en_ff <= pwdata_i[cmp_pkg::BIT_CAPTURE_ROUTE];
        end
    end

    // event mode, reserved code gives no events
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mode_ff <= cmp_pkg::RST_CTRL[cmp_pkg::BIT_MODE_HIGH:cmp_pkg::BIT_MODE_LOW];
        end else if (wr_ctrl) begin
            mode_ff <= pwdata_i[cmp_pkg::BIT_MODE_HIGH:cmp_pkg::BIT_MODE_LOW];
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            neg_mux_en_ff <= cmp_pkg::RST_SPIO[cmp_pkg::BIT_NEG_MUX_EN];
        end else if (wr_spio) begin
            neg_mux_en_ff <= pwdata_i[cmp_pkg::BIT_NEG_MUX_EN];
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            chan_ff    <= cmp_pkg::RST_MUX[2:0];
            conv_en_ff <= cmp_pkg::RST_MUX[cmp_pkg::BIT_CONV_ENABLE];
        end else if (wr_mux) begin
            chan_ff    <= pwdata_i[cmp_pkg::CHAN_LSB +: cmp_pkg::CHAN_WIDTH];
            conv_en_ff <= pwdata_i[cmp_pkg::BIT_CONV_ENABLE];
        end
    end

    // ****************************************************
    // event flag
    // ****************************************************
    always_comb begin
        nxt_event = event_flag_ff;
        if (vector_ack_i) begin
            nxt_event = 1'b0;
        end
        if (wr_ctrl && pwdata_i[cmp_pkg::BIT_EVENT_FLAG]) begin
            nxt_event = 1'b0;
        end
        if (mode_match(mode_ff, sync_if.rise, sync_if.fall)) begin
            nxt_event = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            event_flag_ff <= cmp_pkg::RST_CTRL[cmp_pkg::BIT_EVENT_FLAG];
        end else begin
            event_flag_ff <= nxt_event;
        end
    end

    // ****************************************************
    // sticky interrupt status and mask
    // ****************************************************
    assign irq_set[cmp_pkg::IRQ_BIT_EVENT] = mode_match(mode_ff, sync_if.rise, sync_if.fall);
    assign irq_set[cmp_pkg::IRQ_BIT_RISE]  = sync_if.rise;
    assign irq_set[cmp_pkg::IRQ_BIT_FALL]  = sync_if.fall;

    genvar gi;
    generate
        for (gi = 0; gi < cmp_pkg::IRQ_WIDTH; gi++) begin : g_irq
            always_ff @(posedge clk_i) begin
                if (reset_i) begin
                    irq_status_ff[gi] <= 1'b0;
                end else if (irq_set[gi]) begin
                    irq_status_ff[gi] <= 1'b1;
                end else if (wr_stat && pwdata_i[gi]) begin
                    irq_status_ff[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            irq_mask_ff <= cmp_pkg::RST_MASK;
        end else if (wr_mask) begin
            irq_mask_ff <= pwdata_i[cmp_pkg::IRQ_WIDTH-1:0];
        end
    end

    // ****************************************************
    // analog steering and outputs
    // ****************************************************
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cmp_power_off_o <= 1'b0;
        end else begin
            cmp_power_off_o <= power_off_ff;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            bandgap_select_o <= 1'b0;
        end else begin
            bandgap_select_o <= bandgap_ff;
        end
    end

    // channel mux only while converter off
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            neg_from_mux_o <= 1'b0;
        end else begin
            neg_from_mux_o <= neg_mux_en_ff & ~conv_en_ff;
        end
    end

    // channel forced to zero while pin used
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            channel_select_o <= 3'h0;
        end else begin
            channel_select_o <= (neg_mux_en_ff & ~conv_en_ff) ? chan_ff : 3'h0;
        end
    end

    // synchronized result, gated by route enable
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            capture_input_o <= 1'b0;
        end else begin
            capture_input_o <= capture_en_ff & sync_if.level;
        end
    end

    // follows next flag value
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cmp_irq_req_o <= 1'b0;
        end else begin
            cmp_irq_req_o <= nxt_event & irq_en_ff & global_irq_enable_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_status_ff & irq_mask_ff);
        end
    end

    // ****************************************************
    // read data
    // ****************************************************
    always_comb begin
        ctrl_rd = 8'h00;
        ctrl_rd[cmp_pkg::BIT_POWER_OFF]     = power_off_ff;
        ctrl_rd[cmp_pkg::BIT_BANDGAP_SEL]   = bandgap_ff;
        ctrl_rd[cmp_pkg::BIT_OUTPUT_FLAG]   = sync_if.level;
        ctrl_rd[cmp_pkg::BIT_EVENT_FLAG]    = event_flag_ff;
        ctrl_rd[cmp_pkg::BIT_IRQ_ENABLE]    = irq_en_ff;
        ctrl_rd[cmp_pkg::BIT_CAPTURE_ROUTE] = capture_en_ff;
        ctrl_rd[cmp_pkg::BIT_MODE_HIGH:cmp_pkg::BIT_MODE_LOW] = mode_ff;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (rd_en) begin
            unique case (1'b1)
                addr_is(paddr_i, cmp_pkg::OFS_CTRL_STATUS): prdata_o <= {24'h000000, ctrl_rd};
                addr_is(paddr_i, cmp_pkg::OFS_SPECIAL_IO):  prdata_o <= {28'h0000000, neg_mux_en_ff, 3'h0};
                addr_is(paddr_i, cmp_pkg::OFS_IRQ_STATUS):  prdata_o <= {29'h00000000, irq_status_ff};
                addr_is(paddr_i, cmp_pkg::OFS_IRQ_MASK):    prdata_o <= {29'h00000000, irq_mask_ff};
                addr_is(paddr_i, cmp_pkg::OFS_MUX_CTRL):    prdata_o <= {28'h0000000, conv_en_ff, chan_ff};
                default:                                    prdata_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule // comparator_control_logic

// ---- cmp_analog_model.sv ----
// model: analog comparator core with input selection
`timescale 1ns/1ps
module cmp_analog_model (
    input  wire logic       power_off_i,
    input  wire logic       bandgap_i,
    input  wire logic       neg_mux_i,
    input  wire logic [2:0] chan_i,
    input  var int          pos_mv_i,
    input  var int          neg_mv_i,
    input  var int          bg_mv_i,
    input  var int          ch_mv_i [8],
    output logic            raw_o
);
    int pos_mv;
    int neg_mv;
    // ****
    // comparison, dead when powered off
    // ****
    assign pos_mv = bandgap_i ? bg_mv_i : pos_mv_i;
    assign neg_mv = neg_mux_i ? ch_mv_i[chan_i] : neg_mv_i;
    assign raw_o  = !power_off_i && (pos_mv > neg_mv);
endmodule // cmp_analog_model

// ---- comparator_control_logic_chk.sv ----
// checker: port-level assertions for the comparator control block
`timescale 1ns/1ps
module comparator_control_logic_chk (
    input wire logic       clk_i,
    input wire logic       reset_i,
    input wire logic       psel_i,
    input wire logic       penable_i,
    input wire logic       pready_o,
    input wire logic       pslverr_o,
    input wire logic       cmp_raw_i,
    input wire logic       global_irq_enable_i,
    input wire logic       vector_ack_i,
    input wire logic       neg_from_mux_o,
    input wire logic [2:0] channel_select_o,
    input wire logic       capture_input_o,
    input wire logic       cmp_irq_req_o,
    input wire logic       irq_o
);
    // ****
    // assertions
    // ****
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    property p_ready_setup;
        psel_i && !penable_i |=> pready_o;
    endproperty
    a_ready_setup: assert property (p_ready_setup) else $error("pready late after setup");
    property p_ready_access;
        pready_o |-> psel_i && penable_i ##1 !pready_o;
    endproperty
    a_ready_access: assert property (p_ready_access) else $error("pready outside access");
    property p_err_ready;
        pslverr_o |-> pready_o;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
    property p_irq_gie;
        cmp_irq_req_o |-> $past(global_irq_enable_i);
    endproperty
    a_irq_gie: assert property (p_irq_gie) else $error("irq request without global enable");
    property p_irq_ack;
        vector_ack_i |-> ##2 !cmp_irq_req_o;
    endproperty
    a_irq_ack: assert property (p_irq_ack) else $error("irq request kept after vector");
    property p_cap_lag;
        capture_input_o |-> $past(cmp_raw_i, 2) || $past(cmp_raw_i, 3);
    endproperty
    a_cap_lag: assert property (p_cap_lag) else $error("capture input without result");
    property p_chan_idle;
        !neg_from_mux_o |-> channel_select_o == 3'h0;
    endproperty
    a_chan_idle: assert property (p_chan_idle) else $error("channel set while pin used");
    property p_reset_out;
        $fell(reset_i) |-> !(pready_o || irq_o || cmp_irq_req_o || capture_input_o || neg_from_mux_o);
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("output high after reset");
endmodule // comparator_control_logic_chk

// ---- tb_comparator_control_logic.sv ----
// testbench: comparator control block
`timescale 1ns/1ps
module tb_comparator_control_logic;
    logic        clk_i = 0, reset_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, rerr;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rdat;
    logic        pready_o, pslverr_o, cmp_raw_i, global_irq_enable_i = 0, vector_ack_i = 0;
    logic        cmp_power_off_o, bandgap_select_o, neg_from_mux_o, capture_input_o, cmp_irq_req_o, irq_o;
    logic [2:0]  channel_select_o;
    int          pos_mv = 1000, neg_mv = 1500, bg_mv = 2000, num_errors = 0, total_checks = 0, cycles = 0;
    int          ch_mv [8] = '{default: 3000};
    always #20 clk_i = ~clk_i;
    comparator_control_logic dut (.clk_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .cmp_raw_i, .global_irq_enable_i, .vector_ack_i, .cmp_power_off_o,
        .bandgap_select_o, .neg_from_mux_o, .channel_select_o, .capture_input_o, .cmp_irq_req_o, .irq_o);
    cmp_analog_model ana (.power_off_i(cmp_power_off_o), .bandgap_i(bandgap_select_o),
        .neg_mux_i(neg_from_mux_o), .chan_i(channel_select_o), .pos_mv_i(pos_mv), .neg_mv_i(neg_mv),
        .bg_mv_i(bg_mv), .ch_mv_i(ch_mv), .raw_o(cmp_raw_i));
    // ****
    // helpers
    // ****
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1; penable_i <= 0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        rdat = prdata_o;
        rerr = pslverr_o;
        psel_i <= 0; penable_i <= 0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d); apb(1, a, d); repeat (2) @(posedge clk_i); endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input string n); apb(0, a, 0); chk(n, e, rdat); endtask
    task rawset(input int v); pos_mv <= v; repeat (6) @(posedge clk_i); endtask
    task test_done;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ****
    // scenarios
    // ****
    task t_reset;
        rd(cmp_pkg::OFS_CTRL_STATUS, cmp_pkg::RST_CTRL, "ctrl");
        rd(cmp_pkg::OFS_SPECIAL_IO, cmp_pkg::RST_SPIO, "spio");
        rd(cmp_pkg::OFS_IRQ_MASK, cmp_pkg::RST_MASK, "mask");
        rd(cmp_pkg::OFS_MUX_CTRL, cmp_pkg::RST_MUX, "mux");
        rd(8'h14, 32'h0, "unmapped");
        chk("slverr", 1, rerr);
    endtask
    task t_events;
        logic [1:0] m;
        logic       ev;
        for (int i = 0; i < 4; i++) begin
            m = i[1:0];
            wr(cmp_pkg::OFS_CTRL_STATUS, {27'h0, 3'b100, m});
            rawset(2000);
            ev = (m == 2'b00 || m == 2'b11);
            rd(cmp_pkg::OFS_CTRL_STATUS, {24'h0, 3'b001, ev, 2'b00, m}, "rise");
            wr(cmp_pkg::OFS_CTRL_STATUS, {30'h0, m});
            rd(cmp_pkg::OFS_CTRL_STATUS, {24'h0, 3'b001, ev, 2'b00, m}, "keep");
            wr(cmp_pkg::OFS_CTRL_STATUS, {27'h0, 3'b100, m});
            rawset(1000);
            ev = (m == 2'b00 || m == 2'b10);
            rd(cmp_pkg::OFS_CTRL_STATUS, {27'h0, ev, 2'b00, m}, "fall");
        end
    endtask
    task t_irq;
        wr(cmp_pkg::OFS_IRQ_STATUS, 32'h7);
        wr(cmp_pkg::OFS_CTRL_STATUS, 32'h1b);
        global_irq_enable_i <= 1;
        rawset(2000);
        chk("irq_req", 1, cmp_irq_req_o);
        @(posedge clk_i) vector_ack_i <= 1;
        @(posedge clk_i) vector_ack_i <= 0;
        repeat (3) @(posedge clk_i);
        chk("ack", 0, cmp_irq_req_o);
        rd(cmp_pkg::OFS_CTRL_STATUS, 32'h2b, "ack_flag");
        global_irq_enable_i <= 0;
        rawset(1000);
        rawset(2000);
        chk("no_gie", 0, cmp_irq_req_o);
        global_irq_enable_i <= 1;
        repeat (3) @(posedge clk_i);
        chk("gie", 1, cmp_irq_req_o);
        wr(cmp_pkg::OFS_CTRL_STATUS, 32'h03);
        chk("ie_off", 0, cmp_irq_req_o);
        rd(cmp_pkg::OFS_IRQ_STATUS, 32'h7, "irq_stat");
        wr(cmp_pkg::OFS_IRQ_MASK, 32'h1);
        chk("irq_on", 1, irq_o);
        wr(cmp_pkg::OFS_IRQ_STATUS, 32'h7);
        chk("irq_clr", 0, irq_o);
        wr(cmp_pkg::OFS_IRQ_MASK, 32'h0);
        rawset(1000);
        rawset(2000);
        chk("irq_masked", 0, irq_o);
        wr(cmp_pkg::OFS_IRQ_MASK, 32'h1);
        chk("irq_unmask", 1, irq_o);
    endtask
    task t_io;
        wr(cmp_pkg::OFS_CTRL_STATUS, 32'h15);
        chk("cap_on", 1, capture_input_o);
        rawset(1000);
        chk("cap_low", 0, capture_input_o);
        wr(cmp_pkg::OFS_CTRL_STATUS, 32'h01);
        rawset(2000);
        chk("cap_off", 0, capture_input_o);
        wr(cmp_pkg::OFS_CTRL_STATUS, 32'h81);
        chk("power", 1, cmp_power_off_o);
        rawset(1000);
        wr(cmp_pkg::OFS_CTRL_STATUS, 32'h41);
        chk("bandgap_pin", 1, bandgap_select_o);
        repeat (4) @(posedge clk_i);
        rd(cmp_pkg::OFS_CTRL_STATUS, 32'h61, "bandgap");
        wr(cmp_pkg::OFS_CTRL_STATUS, 32'h01);
        repeat (4) @(posedge clk_i);
        rd(cmp_pkg::OFS_CTRL_STATUS, 32'h01, "pin");
        wr(cmp_pkg::OFS_SPECIAL_IO, 32'h08);
        for (int c = 0; c < 8; c++) begin
            wr(cmp_pkg::OFS_MUX_CTRL, c);
            chk("chan", c, channel_select_o);
        end
        ch_mv[5] <= 500;
        wr(cmp_pkg::OFS_MUX_CTRL, 32'h05);
        repeat (4) @(posedge clk_i);
        chk("neg_mux", 1, neg_from_mux_o);
        rd(cmp_pkg::OFS_CTRL_STATUS, 32'h21, "mux_cmp");
        wr(cmp_pkg::OFS_MUX_CTRL, 32'h0d);
        repeat (4) @(posedge clk_i);
        chk("conv_on", 0, neg_from_mux_o);
        rd(cmp_pkg::OFS_CTRL_STATUS, 32'h01, "conv_cmp");
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        reset_i <= 0;
        t_reset;
        t_events;
        t_irq;
        t_io;
        test_done;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            test_done;
        end
    end
endmodule // tb_comparator_control_logic
bind comparator_control_logic comparator_control_logic_chk chk (.clk_i, .reset_i, .psel_i, .penable_i, .pready_o,
    .pslverr_o, .cmp_raw_i, .global_irq_enable_i, .vector_ack_i, .neg_from_mux_o, .channel_select_o,
    .capture_input_o, .cmp_irq_req_o, .irq_o);
